// >>> common/dpe_pkg.sv
package dpe_pkg;

  // Clock and timing
  localparam int CLK_NS      = 20;
  localparam int T_STROBE_NS = 40;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WB_NS     = 100;
  localparam int WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS;

  // Flash opcodes
  localparam logic [7:0] OPC_ERASE   = 8'h60;
  localparam logic [7:0] OPC_CONFIRM = 8'hd0;
  localparam logic [7:0] OPC_STAT    = 8'h70;
  localparam logic [7:0] OPC_STAT_PD = 8'h78;
  localparam logic [7:0] OPC_RESET   = 8'hff;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_ADDR0 = 12'h004;
  localparam logic [11:0] REG_ADDR1 = 12'h008;
  localparam logic [11:0] REG_STAT  = 12'h00c;

  // Control fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_WP_BIT   = 4;

  // Status register fields
  localparam int STAT_BUSY = 8;
  localparam int STAT_RB   = 9;
  localparam int STAT_ERR  = 10;
  localparam int STAT_P0F  = 11;
  localparam int STAT_P1F  = 12;
  localparam int STAT_ILV  = 13;
  localparam int STAT_POR  = 14;

  // Flash status byte and row address fields
  localparam int FS_FAIL       = 0;
  localparam int ROW_PAGE_MSB  = 5;
  localparam int ROW_PLANE_BIT = 6;
  localparam int ROW_DIE_BIT   = 18;

  // Step indices inside sequences
  localparam logic [3:0] SEQ_CONF1 = 4'h4;
  localparam logic [3:0] SEQ_CONF2 = 4'h8;
  localparam logic [3:0] SEQ_RD0   = 4'h4;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_ERASE2  = 3'h1,
    OP_ERASE1  = 3'h2,
    OP_STAT    = 3'h3,
    OP_STAT_PD = 3'h4,
    OP_RESET   = 3'h5,
    OP_CHECK   = 3'h6
  } dpe_op_t;

  typedef enum logic [2:0] {
    IT_CMD  = 3'h0,
    IT_ADR  = 3'h1,
    IT_RD   = 3'h2,
    IT_WAIT = 3'h3,
    IT_END  = 3'h4
  } dpe_item_t;

  typedef struct packed {
    dpe_item_t  kind;
    logic [7:0] data;
  } dpe_step_t;

endpackage

// >>> common/dpe_strb_if.sv
`timescale 1ns/100ps
interface dpe_strb_if;
  import dpe_pkg::*;
  logic       req;
  dpe_item_t  kind;
  logic [7:0] wdata;
  logic       done;
  logic [7:0] rdata;
  modport ctl (output req, kind, wdata, input done, rdata);
  modport phy (input req, kind, wdata, output done, rdata);
endinterface

// >>> dv/dpe_flash_model.sv
`timescale 1ns/100ps
module dpe_flash_model #(
  parameter int ERASE_CYC = 40,
  parameter int RST_CYC   = 3
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pins from controller
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic       wp_n_i,
  input  wire logic [7:0] io_i,
  input  wire logic [3:0] fail_i,
  // Towards controller
  output logic      [7:0] io_o,
  output logic            rb_n_o,
  output logic      [7:0] ncmd_o,
  output logic      [7:0] nadr_o
);
  logic [1:0][15:0] cnt_q;
  logic [3:0]       pend_q, pf_q;
  logic [7:0]       op_q, last_q;
  logic [1:0]       acnt_q;
  logic             we_q, die_q, pl_q, pd_q, rdy, fl;

  always_ff @(posedge clk_i) begin
    last_q <= io_o;
    we_q   <= we_n_i;
    if (rst_i) begin
      {cnt_q, pend_q, pf_q, op_q, acnt_q} <= '0;
      {die_q, pl_q, pd_q, ncmd_o, nadr_o} <= '0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (cnt_q[d] != 0) cnt_q[d] <= cnt_q[d] - 1;
      end
      if (!we_q && we_n_i && !ce_n_i && cle_i) begin
        // No opcode is refused while a die is busy
        ncmd_o <= ncmd_o + 1;
        op_q   <= io_i;
        acnt_q <= 0;
        if (io_i == 8'hd0) begin
          // Both dies may start here, each busy on its own count
          for (int d = 0; d < 2; d++) begin
            if (pend_q[2*d+:2] != 0) begin
              cnt_q[d]      <= ERASE_CYC[15:0];
              pf_q[2*d+:2]  <= fail_i[2*d+:2] & pend_q[2*d+:2];
            end
          end
          pend_q <= '0;
        end
        if (io_i == 8'h70) pd_q <= 1'b0;
        if (io_i == 8'hff) begin
          cnt_q  <= {2{RST_CYC[15:0]}};
          pend_q <= '0;
          pf_q   <= '0;
          pd_q   <= 1'b0;
        end
      end else if (!we_q && we_n_i && !ce_n_i && ale_i) begin
        nadr_o <= nadr_o + 1;
        acnt_q <= acnt_q + 1;
        if (acnt_q == 0) pl_q <= io_i[6];
        if (acnt_q == 2) begin
          die_q <= io_i[2];
          if (op_q == 8'h60) pend_q[{io_i[2], pl_q}] <= 1'b1;
          if (op_q == 8'h78) pd_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    rdy    = cnt_q[die_q] == 0;
    fl     = pd_q ? pf_q[{die_q, pl_q}] : |pf_q[2*die_q+:2];
    rb_n_o = cnt_q[0] == 0 && cnt_q[1] == 0;
    // Only the addressed die answers; an idle bus never holds a value
    io_o = !re_n_i ? {wp_n_i, rdy, rdy, 4'h0, fl} : ~last_q;
  end
endmodule

// >>> dv/dpe_host_assertions.sv
`timescale 1ns/100ps
module dpe_host_chk
  import dpe_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Flash pins
  input wire logic        ce_n_o,
  input wire logic        cle_o,
  input wire logic        ale_o,
  input wire logic        we_n_o,
  input wire logic        re_n_o,
  input wire logic        wp_n_o,
  input wire logic        io_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("answer without setup");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("bus error outside access");
  latch_excl_a: assert property (!(cle_o && ale_o))
    else $error("command and address latch together");
  drive_latch_a: assert property (cle_o || ale_o |-> !io_oe_n_o)
    else $error("latch byte not driven");
  write_pulse_a: assert property ($fell(we_n_o) |=>
    !we_n_o ##1 we_n_o [*2])
    else $error("write strobe shape wrong");
  read_pulse_a: assert property ($fell(re_n_o) |=>
    !re_n_o ##1 re_n_o [*2])
    else $error("read strobe shape wrong");
  read_release_a: assert property (!re_n_o |-> io_oe_n_o && !cle_o)
    else $error("bus driven while reading");
  select_low_a: assert property (!we_n_o || !re_n_o |-> !ce_n_o)
    else $error("strobe without chip enable");
  wp_ctrl_a: assert property (psel_i && penable_i && pready_o && pwrite_i
    && paddr_i == REG_CTRL |=> ##1 wp_n_o == !$past(pwdata_i[CTRL_WP_BIT], 2))
    else $error("write protect pin not following control");
endmodule

bind dpe_host dpe_host_chk i_dpe_host_chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
  .ce_n_o, .cle_o, .ale_o, .we_n_o, .re_n_o, .wp_n_o, .io_oe_n_o);

// >>> dv/tb_dpe_host.sv
`timescale 1ns/100ps
module tb_dpe_host;
  import dpe_pkg::*;
  logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, perr, rb_n, pready_o, pslverr_o;
  logic        ce_n_o, cle_o, ale_o, we_n_o, re_n_o, wp_n_o, io_oe_n_o;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [7:0]  io_o, fl_io, bus, ncmd, nadr;
  logic [3:0]  fail = 0;
  int          err_count = 0, num_checks = 0;

  always #10 clk_i = ~clk_i;
  assign bus = io_oe_n_o ? fl_io : io_o;

  dpe_host i_dpe_host (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ce_n_o, .cle_o,
    .ale_o, .we_n_o, .re_n_o, .wp_n_o, .io_o, .io_oe_n_o, .io_i(bus),
    .ready_busy_n_i(rb_n));
  dpe_flash_model #(.ERASE_CYC(200)) i_dpe_flash_model (.clk_i, .rst_i,
    .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .re_n_i(re_n_o), .wp_n_i(wp_n_o), .io_i(io_o), .fail_i(fail),
    .io_o(fl_io), .rb_n_o(rb_n), .ncmd_o(ncmd), .nadr_o(nadr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i) penable_i <= 1'b1;
    // No wait count is assumed; the watchdog ends a hung transfer
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd   = prdata_o;
    perr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_idle;
    do apb(1'b0, REG_STAT, '0); while (rd[STAT_BUSY] !== 1'b0);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, REG_STAT, '0);
    chk(rd & 32'h0000_7f00, 32'h0000_4200);
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    apb(1'b0, REG_STAT, '0);
    chk(rd & 32'h0000_0400, 32'h0000_0400);
    apb(1'b1, REG_STAT, 32'h0000_0400);
    apb(1'b0, REG_STAT, '0);
    chk(rd & 32'h0000_0400, 32'h0000_0000);
    apb(1'b0, 12'h010, '0);
    chk({rd[31:1], perr}, 32'h0000_0001);
    // Plane one of die zero fails its erase
    fail <= 4'b0010;
    apb(1'b1, REG_ADDR0, 32'h0000_0000);
    apb(1'b1, REG_ADDR1, 32'h0000_0040);
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    wait_idle;
    chk(rd & 32'h0000_18ff, 32'h0000_10e1);
    chk({24'h0, ncmd}, 32'h0000_0006);
    chk({24'h0, nadr}, 32'h0000_000c);
    // Per-plane read of the passing plane, now that an erase has run
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_idle;
    chk(rd & 32'h0000_44ff, 32'h0000_00e0);
    apb(1'b1, REG_CTRL, 32'h0000_0013);
    wait_idle;
    chk(rd & 32'h0000_00ff, 32'h0000_0061);
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    wait_idle;
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    wait_idle;
    chk(rd & 32'h0000_20ff, 32'h0000_00e0);
    // Die zero stays busy while die one is started
    fail <= 4'b0000;
    apb(1'b1, REG_ADDR0, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    wait_idle;
    chk(rd & 32'h0000_0300, 32'h0000_0000);
    apb(1'b1, REG_ADDR0, 32'h0004_0000);
    apb(1'b1, REG_CTRL, 32'h0000_000a);
    wait_idle;
    chk(rd & 32'h0000_22ff, 32'h0000_22e0);
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    apb(1'b0, REG_STAT, '0);
    chk(rd & 32'h0000_0400, 32'h0000_0400);
    end_sim;
  end
endmodule

// >>> logic/dpe_host.sv
// How it works
// - Erase pair: 60h, 3 addr, 60h, 3 addr, D0h
// - During erase only 70h, 78h, FFh sent; code also sends 60h while busy when the erase targets die one
// - Fail after pair erase: 78h per plane
// - 78h followed by exactly three address cycles
// - Per-plane read valid except pair page read
// - No 70h during interleave; use 78h
// - No 78h after power-on reset
// - Interleave: die zero first, then die one
// - Interleaved pairs keep pair addressing rules
// - Pair blocks: other plane, same die, page zero
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module dpe_host (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Flash pins
  output logic                    ce_n_o,
  output logic                    cle_o,
  output logic                    ale_o,
  output logic                    we_n_o,
  output logic                    re_n_o,
  output logic                    wp_n_o,
  output logic      [7:0]         io_o,
  output logic                    io_oe_n_o,
  input  wire logic [7:0]         io_i,
  input  wire logic               ready_busy_n_i
);
  import dpe_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_XFER = 4'b0100,
    ST_WAIT = 4'b1000
  } dpe_st_t;

  typedef struct packed {
    dpe_st_t     st;
    dpe_op_t     op;
    logic [3:0]  seq;
    logic [23:0] a0;
    logic [23:0] a1;
    logic        autochk;
    logic        wp_n;
    logic [7:0]  stat;
    logic        p0f;
    logic        p1f;
    logic        err;
    logic        ilv;
    logic        por;
    logic [3:0]  cnt;
    logic        req;
    dpe_item_t   kind;
    logic [7:0]  wdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dpe_host_state_t;

  localparam logic [3:0] WB_LAST = 4'(WB_CYC - 1);

  dpe_host_state_t q, d;
  dpe_strb_if      xf ();

  function automatic logic [7:0] abyte(input logic [23:0] a,
                                       input logic [3:0]  i);
    logic [7:0] b;
    unique case (i[1:0])
      2'h0:    b = a[7:0];
      2'h1:    b = a[15:8];
      default: b = a[23:16];
    endcase
    return b;
  endfunction

  function automatic dpe_step_t step(input dpe_op_t     op,
                                     input logic [3:0]  s,
                                     input logic [23:0] a0,
                                     input logic [23:0] a1,
                                     input logic        autochk);
    dpe_step_t  r;
    logic       two;
    logic [3:0] c;
    r   = '{kind: IT_END, data: 8'h00};
    two = (op == OP_ERASE2);
    c   = two ? SEQ_CONF2 : SEQ_CONF1;
    unique case (op)
      OP_ERASE1, OP_ERASE2: begin
        if (s == 4'h0 || (two && s == SEQ_CONF1)) begin
          r = '{kind: IT_CMD, data: OPC_ERASE};
        end else if (s < SEQ_CONF1) begin
          r = '{kind: IT_ADR, data: abyte(a0, s - 4'h1)};
        end else if (two && s < SEQ_CONF2) begin
          r = '{kind: IT_ADR, data: abyte(a1, s - 4'h5)};
        end else if (s == c) begin
          r = '{kind: IT_CMD, data: OPC_CONFIRM};
        end else if (s == c + 4'h1) begin
          r.kind = autochk ? IT_WAIT : IT_END;
        end else if (s == c + 4'h2) begin
          r = '{kind: IT_CMD, data: OPC_STAT};
        end else if (s == c + 4'h3) begin
          r.kind = IT_RD;
        end
      end
      OP_STAT: begin
        if (s == 4'h0) begin
          r = '{kind: IT_CMD, data: OPC_STAT};
        end else if (s == 4'h1) begin
          r.kind = IT_RD;
        end
      end
      OP_STAT_PD, OP_CHECK: begin
        if (s == 4'h0 || (op == OP_CHECK && s == 4'h5)) begin
          r = '{kind: IT_CMD, data: OPC_STAT_PD};
        end else if (s < SEQ_RD0) begin
          r = '{kind: IT_ADR, data: abyte(a0, s - 4'h1)};
        end else if (s == SEQ_RD0 || (op == OP_CHECK && s == 4'h9)) begin
          r.kind = IT_RD;
        end else if (op == OP_CHECK && s < 4'h9) begin
          r = '{kind: IT_ADR, data: abyte(a1, s - 4'h6)};
        end
      end
      OP_RESET: begin
        if (s == 4'h0) begin
          r = '{kind: IT_CMD, data: OPC_RESET};
        end else if (s == 4'h1) begin
          r.kind = IT_WAIT;
        end
      end
      default: r.kind = IT_END;
    endcase
    return r;
  endfunction

  dpe_step_t it;
  dpe_op_t   new_op;
  logic      wr_acc;
  logic      rd_set;
  logic      mapped;
  logic      pair_ok;
  logic      op_ok;
  logic      rb;

  assign rb     = ready_busy_n_i;
  assign it     = step(q.op, q.seq, q.a0, q.a1, q.autochk);
  assign new_op = dpe_op_t'(pwdata_i[CTRL_OP_LSB +: 3]);
  assign wr_acc = psel_i & penable_i & q.pready & pwrite_i;
  assign rd_set = psel_i & ~penable_i;
  assign mapped = (paddr_i == REG_CTRL) | (paddr_i == REG_ADDR0) |
                  (paddr_i == REG_ADDR1) | (paddr_i == REG_STAT);

  // Both blocks on one die, opposite planes, page bits zero
  assign pair_ok = (q.a0[ROW_PAGE_MSB:0] == '0) &&
                   (q.a1[ROW_PAGE_MSB:0] == '0) &&
                   (q.a0[ROW_PLANE_BIT] != q.a1[ROW_PLANE_BIT]) &&
                   (q.a0[ROW_DIE_BIT] == q.a1[ROW_DIE_BIT]);

  always_comb begin
    unique case (new_op)
      OP_ERASE1: op_ok = rb || q.a0[ROW_DIE_BIT];
      OP_ERASE2: op_ok = pair_ok && (rb || q.a0[ROW_DIE_BIT]);
      OP_STAT:    op_ok = !q.ilv;
      OP_STAT_PD: op_ok = !q.por;
      OP_RESET:   op_ok = 1'b1;
      default:    op_ok = 1'b0;
    endcase
  end

  always_comb begin
    d         = q;
    d.req     = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // Error flag: software clear first so a same-cycle refusal wins
    if (wr_acc && paddr_i == REG_STAT && pwdata_i[STAT_ERR]) begin
      d.err = 1'b0;
    end

    unique case (q.st)
      ST_IDLE: ;
      ST_RUN: begin
        unique case (it.kind)
          IT_CMD, IT_ADR, IT_RD: begin
            if (it.data == OPC_STAT && it.kind == IT_CMD && q.ilv &&
                q.op != OP_STAT) begin
              // Interleaved: a 78h per-plane check replaces the 70h poll here
              d.op  = OP_CHECK;
              d.seq = 4'h0;
            end else begin
              d.req   = 1'b1;
              d.kind  = it.kind;
              d.wdata = it.data;
              d.st    = ST_XFER;
            end
          end
          IT_WAIT: begin
            d.cnt = WB_LAST;
            d.st  = ST_WAIT;
          end
          default: begin
            if (q.op == OP_ERASE2 && q.autochk && q.stat[FS_FAIL]) begin
              d.op  = OP_CHECK;
              d.seq = 4'h0;
            end else begin
              d.st = ST_IDLE;
            end
          end
        endcase
      end
      ST_XFER: begin
        if (xf.done) begin
          if (q.kind == IT_RD) begin
            d.stat = xf.rdata;
            if (q.op == OP_CHECK) begin
              if (q.seq == SEQ_RD0) begin
                d.p0f = xf.rdata[FS_FAIL];
              end else begin
                d.p1f = xf.rdata[FS_FAIL];
              end
            end
          end
          d.seq = q.seq + 4'h1;
          d.st  = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else if (rb) begin
          d.seq = q.seq + 4'h1;
          d.st  = ST_RUN;
        end
      end
    endcase

    if (wr_acc) begin
      unique case (paddr_i)
        REG_CTRL: begin
          d.autochk = pwdata_i[CTRL_AUTO_BIT];
          d.wp_n    = ~pwdata_i[CTRL_WP_BIT];
          if (new_op != OP_NONE) begin
            // Only a reset may break into a busy wait
            if ((q.st == ST_IDLE || (q.st == ST_WAIT &&
                 new_op == OP_RESET)) && op_ok) begin
              d.op  = new_op;
              d.seq = 4'h0;
              d.st  = ST_RUN;
              if (new_op == OP_ERASE1 || new_op == OP_ERASE2) begin
                d.ilv = !rb;
                d.por = 1'b0;
                d.p0f = 1'b0;
                d.p1f = 1'b0;
              end
              if (new_op == OP_RESET) begin
                d.ilv = 1'b0;
              end
            end else begin
              d.err = 1'b1;
            end
          end
        end
        REG_ADDR0, REG_ADDR1: begin
          if (q.st == ST_IDLE) begin
            if (paddr_i == REG_ADDR0) begin
              d.a0 = pwdata_i[23:0];
            end else begin
              d.a1 = pwdata_i[23:0];
            end
          end else begin
            d.err = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (rd_set) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      unique case (paddr_i)
        REG_CTRL: d.prdata = {27'h000_0000, ~q.wp_n, q.autochk, q.op};
        REG_ADDR0: d.prdata = {8'h00, q.a0};
        REG_ADDR1: d.prdata = {8'h00, q.a1};
        REG_STAT: d.prdata = {17'h0_0000, q.por, q.ilv, q.p1f, q.p0f,
                              q.err, rb, (q.st != ST_IDLE), q.stat};
        default:  d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.op   <= OP_NONE;
      q.kind <= IT_END;
      q.por  <= 1'b1;
      q.wp_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign xf.req    = q.req;
  assign xf.kind   = q.kind;
  assign xf.wdata  = q.wdata;
  assign prdata_o  = q.prdata;
  assign pready_o  = q.pready;
  assign pslverr_o = q.pslverr;
  assign wp_n_o    = q.wp_n;

  dpe_strobe u_strobe (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .xf        (xf.phy),
    .io_i      (io_i),
    .ce_n_o    (ce_n_o),
    .cle_o     (cle_o),
    .ale_o     (ale_o),
    .we_n_o    (we_n_o),
    .re_n_o    (re_n_o),
    .io_o      (io_o),
    .io_oe_n_o (io_oe_n_o)
  );

endmodule

// >>> logic/dpe_strobe.sv
`timescale 1ns/100ps
module dpe_strobe (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Request from sequencer
  dpe_strb_if.phy         xf,
  // Flash pins
  input  wire logic [7:0] io_i,
  output logic            ce_n_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            re_n_o,
  output logic [7:0]      io_o,
  output logic            io_oe_n_o
);
  import dpe_pkg::*;

  typedef enum logic [2:0] {
    SB_IDLE = 3'b001,
    SB_LOW  = 3'b010,
    SB_HIGH = 3'b100
  } dpe_sb_t;

  typedef struct packed {
    dpe_sb_t    st;
    logic [3:0] cnt;
    dpe_item_t  kind;
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io;
    logic       oe_n;
    logic       done;
    logic [7:0] rdata;
  } dpe_sb_state_t;

  localparam logic [3:0] PH_LAST = 4'(STROBE_CYC - 1);

  dpe_sb_state_t q, d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      SB_IDLE: begin
        if (xf.req) begin
          d.st   = SB_LOW;
          d.cnt  = PH_LAST;
          d.kind = xf.kind;
          d.ce_n = 1'b0;
          d.cle  = (xf.kind == IT_CMD);
          d.ale  = (xf.kind == IT_ADR);
          d.io   = xf.wdata;
          d.oe_n = (xf.kind == IT_RD);
          d.we_n = (xf.kind == IT_RD);
          d.re_n = (xf.kind != IT_RD);
        end
      end
      SB_LOW: begin
        if (q.cnt == 4'h0) begin
          // Bytes latch on the rising strobe edge
          d.st   = SB_HIGH;
          d.cnt  = PH_LAST;
          d.we_n = 1'b1;
          d.re_n = 1'b1;
          if (q.kind == IT_RD) begin
            d.rdata = io_i;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      SB_HIGH: begin
        if (q.cnt == 4'h0) begin
          d.st   = SB_IDLE;
          d.cle  = 1'b0;
          d.ale  = 1'b0;
          d.oe_n = 1'b1;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q       <= '0;
      q.st    <= SB_IDLE;
      q.kind  <= IT_END;
      q.ce_n  <= 1'b1;
      q.we_n  <= 1'b1;
      q.re_n  <= 1'b1;
      q.oe_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign xf.done   = q.done;
  assign xf.rdata  = q.rdata;
  assign ce_n_o    = q.ce_n;
  assign cle_o     = q.cle;
  assign ale_o     = q.ale;
  assign we_n_o    = q.we_n;
  assign re_n_o    = q.re_n;
  assign io_o      = q.io;
  assign io_oe_n_o = q.oe_n;

endmodule
